// [hw/dct_ctrl_end.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Controller end: issues commands only when spacing allows
module dct_ctrl_end
  import dct_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_req_valid,
  input wire dct_cmd_t i_req_cmd,
  input wire logic [1:0] i_req_bank,
  input wire logic [3:0] i_req_mode,
  input wire logic i_cke_req,
  input wire logic i_sref_req,
  input wire logic i_odt_req,
  input wire logic i_page_2kb,
  input wire logic i_rate_1066,
  input wire logic i_fast_pd_exit,
  input wire logic [2:0] i_additive_latency,
  input wire logic [3:0] i_write_recovery,
  input wire logic [3:0] i_precharge_period_clocks,
  output logic o_req_taken,
  output logic o_power_down,
  output logic o_self_refresh,
  output logic o_clk_stop_ok,
  output logic o_term_seen,
  dct_link_if.ctrl lnk
);

  // ==========================================================
  // State
  dct_cmd_t cmd_r, cmd_nxt;          // Command on the link
  logic [1:0] bank_r, bank_nxt;      // Bank on the link
  logic [3:0] mode_r, mode_nxt;      // Mode value on the link
  logic cke_r, cke_nxt;              // Clock enable pin
  logic odt_r, odt_nxt;              // Termination pin
  logic taken_r, taken_nxt;          // Request accepted pulse
  logic clk_ok_r, clk_ok_nxt;        // Clock may be stopped
  logic term_r;                      // Registered termination status
  dct_pstate_t pst_r, pst_nxt;       // Power state

  // Timers
  logic [NTMR-1:0] ld;
  logic [NTMR-1:0][TW-1:0] ldv;
  logic [NTMR-1:0] z;

  logic legal;                       // Request meets all spacing
  logic go;                          // Issue this cycle
  logic faw_free;                    // A window slot is free
  logic [1:0] faw_slot;              // Free slot to arm
  int lat;                           // Additive latency as int
  int xards;                         // Slow exit wait

  dct_timer_bank #(.N(NTMR), .W(TW)) u_tmr (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_load(ld),
    .i_val(ldv),
    .o_zero(z)
  );

  // ==========================================================
  // Legality of the pending request
  always_comb begin
    lat = int'(i_additive_latency);
    xards = pick(i_rate_1066, TXARDS_1066_CK, TXARDS_800_CK) - lat;
    faw_free = 1'b0;
    faw_slot = 2'h0;
    // Lowest free slot of the rolling four-activate window
    for (int k = 3; k >= 0; k--) begin
      if (z[T_FAW0 + k]) begin
        faw_free = 1'b1;
        faw_slot = 2'(k);
      end
    end
    case (i_req_cmd)
      CMD_ACT: begin
        legal = z[T_RRD] && faw_free && z[T_XNR];
      end
      CMD_RD: begin
        legal = z[T_CCD] && z[T_WTR] && z[T_XRD];
      end
      CMD_WR, CMD_WRA: begin
        legal = z[T_CCD] && z[T_XNR];
      end
      CMD_PRE: begin
        legal = z[T_RTP] && z[T_XNR];
      end
      default: begin
        legal = z[T_XNR];
      end
    endcase
    // Auto-precharge recovery closes the bank to every command
    legal = legal && z[T_DAL0 + int'(i_req_bank)];
    legal = legal && z[T_MRD];
    // One cycle gap after a take lets the user drop the request
    go = i_req_valid && !taken_r && cke_r && i_cke_req && legal;
  end

  // ==========================================================
  // Next command, pins and timer loads
  always_comb begin
    ld = '0;
    ldv = '0;
    cmd_nxt = CMD_NOP;
    bank_nxt = bank_r;
    mode_nxt = mode_r;
    cke_nxt = cke_r;
    odt_nxt = odt_r;
    taken_nxt = 1'b0;
    pst_nxt = pst_r;
    if (go) begin
      cmd_nxt = i_req_cmd;
      bank_nxt = i_req_bank;
      taken_nxt = 1'b1;
      case (i_req_cmd)
        CMD_ACT: begin
          ld[T_RRD] = 1'b1;
          ldv[T_RRD] = ld_cyc(pick(i_page_2kb, TRRD_2K_CYC,
                                   TRRD_1K_CYC));
          ld[T_FAW0 + int'(faw_slot)] = 1'b1;
          ldv[T_FAW0 + int'(faw_slot)] =
            ld_cyc(pick(i_page_2kb, TFAW_2K_CYC, TFAW_1K_CYC));
        end
        CMD_RD: begin
          ld[T_CCD] = 1'b1;
          ldv[T_CCD] = ld_cyc(TCCD_CK);
          // Internal read lags the command by the additive latency
          ld[T_RTP] = 1'b1;
          ldv[T_RTP] = ld_cyc(TRTP_CYC + lat);
        end
        CMD_WR, CMD_WRA: begin
          ld[T_CCD] = 1'b1;
          ldv[T_CCD] = ld_cyc(TCCD_CK);
          ld[T_WTR] = 1'b1;
          ldv[T_WTR] = ld_cyc(WR_BURST_END_CK + lat + TWTR_CYC);
          if (i_req_cmd == CMD_WRA) begin
            ld[T_DAL0 + int'(i_req_bank)] = 1'b1;
            ldv[T_DAL0 + int'(i_req_bank)] =
              ld_cyc(int'(i_write_recovery) +
                     int'(i_precharge_period_clocks));
          end
        end
        CMD_MRS: begin
          mode_nxt = i_req_mode;
          ld[T_MRD] = 1'b1;
          ldv[T_MRD] = ld_cyc(TMRD_CK);
        end
        CMD_REF: begin
          // Auto refresh holds off every command but reads for the refresh cycle
          ld[T_XNR] = 1'b1;
          ldv[T_XNR] = ld_cyc(REFRESH_CYCLE_CYC);
        end
        default: begin
          bank_nxt = i_req_bank;
        end
      endcase
    end else if (cke_r != i_cke_req && z[T_CKE]) begin
      ld[T_CKE] = 1'b1;
      ldv[T_CKE] = ld_cyc(TCKE_CK);
      if (cke_r) begin
        // Entry waits out termination changes and pending work
        if (z[T_ANPD] && z[T_XNR] && z[T_MRD] && !taken_r) begin
          cke_nxt = 1'b0;
          ld[T_DLY] = 1'b1;
          ldv[T_DLY] = ld_cyc(TDELAY_CYC);
          if (i_sref_req) begin
            cmd_nxt = CMD_REF;
            pst_nxt = PS_SREF;
          end else begin
            pst_nxt = PS_PDOWN;
          end
        end else begin
          ld[T_CKE] = 1'b0;
        end
      end else begin
        cke_nxt = 1'b1;
        pst_nxt = PS_ACTIVE;
        ld[T_XNR] = 1'b1;
        ld[T_XRD] = 1'b1;
        ld[T_AXPD] = 1'b1;
        ldv[T_AXPD] = ld_cyc(pick(i_rate_1066, TAXPD_1066_CK,
                                  TAXPD_800_CK));
        if (pst_r == PS_SREF) begin
          ldv[T_XNR] = ld_cyc(TXSNR_CYC);
          ldv[T_XRD] = ld_cyc(TXSRD_CK);
        end else begin
          ldv[T_XNR] = ld_cyc(pick(i_rate_1066, TXP_1066_CK,
                                   TXP_800_CK));
          if (i_fast_pd_exit) begin
            ldv[T_XRD] = ld_cyc(pick(i_rate_1066, TXARD_1066_CK,
                                     TXARD_800_CK));
          end else begin
            ldv[T_XRD] = ld_cyc(xards);
          end
        end
      end
    end
    // Termination pin follows its request once exit latency is over
    if (odt_r != i_odt_req && z[T_AXPD]) begin
      odt_nxt = i_odt_req;
      ld[T_ANPD] = 1'b1;
      ldv[T_ANPD] = ld_cyc(pick(i_rate_1066, TANPD_1066_CK,
                                TANPD_800_CK));
    end
    // Clock may stop only after the hold time past the enable drop
    clk_ok_nxt = !cke_r && z[T_DLY];
  end

  // ==========================================================
  // Registers
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_r <= CMD_NOP;
      bank_r <= 2'h0;
      mode_r <= MODE_RESET;
      cke_r <= 1'b1;
      odt_r <= 1'b0;
      taken_r <= 1'b0;
      clk_ok_r <= 1'b0;
      term_r <= 1'b0;
      pst_r <= PS_ACTIVE;
    end else begin
      cmd_r <= cmd_nxt;
      bank_r <= bank_nxt;
      mode_r <= mode_nxt;
      cke_r <= cke_nxt;
      odt_r <= odt_nxt;
      taken_r <= taken_nxt;
      clk_ok_r <= clk_ok_nxt;
      term_r <= lnk.term_on;
      pst_r <= pst_nxt;
    end
  end

  // ==========================================================
  // Outputs, all straight from flops
  assign lnk.cmd = cmd_r;
  assign lnk.bank = bank_r;
  assign lnk.mode = mode_r;
  assign lnk.cke = cke_r;
  assign lnk.on_die_termination = odt_r;
  assign o_req_taken = taken_r;
  assign o_power_down = pst_r[PS_PDOWN_BIT];
  assign o_self_refresh = pst_r[PS_SREF_BIT];
  assign o_clk_stop_ok = clk_ok_r;
  assign o_term_seen = term_r;

endmodule // dct_ctrl_end
`default_nettype wire

// [include/dct_pkg.sv]
// Overview of operation
// - Activate spacing 7.5/10 ns by page size.
// - At most four activates per 35/45 ns.
// - Column commands at least 2 clocks apart.
// - Write auto-precharge busy for WR plus precharge clocks.
// - Read waits 7.5 ns after write burst end.
// - Precharge waits 7.5 ns after internal read.
// - Clock enable held 3 clocks per level.
// - Self refresh exit: refresh time+10 ns, non-read.
// - Self refresh exit: 200 clocks before read.
// - Precharge power down exit: 3/2 clocks.
// - Fast active power down exit: 3/2 to read.
// - Slow exit: 10/8 minus additive latency to read.
// - Power-down termination turns on within one clock.
// - Power-down termination turns off within one clock.
// - Termination change to power down: 4/3 clocks.
// - After power-down exit, termination control waits 11/8.
// - Mode register set spaced 2 clocks from next.
// - New termination setting applied within 12 ns.
// - Driver drive mode output within 12 ns.
// - Clock runs tIS+tCK+tIH after enable drop.
// - Refresh cycle time is 105 ns.
package dct_pkg;

  // ==========================================================
  // Clock and conversion helpers
  localparam int CLK_PERIOD_PS = 4000;
  localparam int TW = 8;

  // Least time to cycles, never below one
  function automatic int up_cyc(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest time to cycles, never below one
  function automatic int dn_cyc(input int ps);
    int c;
    c = ps / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Timer load for a spacing of n cycles
  function automatic logic [TW-1:0] ld_cyc(input int n);
    return (n > 1) ? TW'(n - 1) : '0;
  endfunction

  // Select between two figures
  function automatic int pick(input logic sel, input int a, input int b);
    return sel ? a : b;
  endfunction

  // ==========================================================
  // Timing figures
  localparam int TRRD_1K_PS = 7500;
  localparam int TRRD_2K_PS = 10000;
  localparam int TFAW_1K_PS = 35000;
  localparam int TFAW_2K_PS = 45000;
  localparam int TCCD_CK = 2;
  localparam int TWTR_PS = 7500;
  localparam int TRTP_PS = 7500;
  localparam int TCKE_CK = 3;
  localparam int REFRESH_CYCLE_TIME_PS = 105000;
  localparam int TXSNR_EXTRA_PS = 10000;
  localparam int TXSRD_CK = 200;
  localparam int TXP_1066_CK = 3;
  localparam int TXP_800_CK = 2;
  localparam int TXARD_1066_CK = 3;
  localparam int TXARD_800_CK = 2;
  localparam int TXARDS_1066_CK = 10;
  localparam int TXARDS_800_CK = 8;
  localparam int TANPD_1066_CK = 4;
  localparam int TANPD_800_CK = 3;
  localparam int TAXPD_1066_CK = 11;
  localparam int TAXPD_800_CK = 8;
  localparam int TMRD_CK = 2;
  localparam int TAOND_CK = 2;
  localparam int TMOD_MAX_PS = 12000;
  localparam int TOIT_MAX_PS = 12000;
  localparam int TIS_PS = 175;
  localparam int TIH_PS = 250;
  localparam int TCK_1066_PS = 1875;
  localparam int TAC_MIN_PS = -350;
  localparam int TAC_MAX_PS = 350;
  localparam int AONPD_MIN_PS = TAC_MIN_PS + 2000;
  localparam int AONPD_MAX_PS = 3 * TCK_1066_PS + TAC_MAX_PS + 1000;
  localparam int AOFPD_MAX_PS = (5 * TCK_1066_PS) / 2 + TAC_MAX_PS + 1000;
  localparam int WR_BURST_END_CK = 6;

  // Derived cycle counts
  localparam int TRRD_1K_CYC = up_cyc(TRRD_1K_PS);
  localparam int TRRD_2K_CYC = up_cyc(TRRD_2K_PS);
  localparam int TFAW_1K_CYC = up_cyc(TFAW_1K_PS);
  localparam int TFAW_2K_CYC = up_cyc(TFAW_2K_PS);
  localparam int TWTR_CYC = up_cyc(TWTR_PS);
  localparam int TRTP_CYC = up_cyc(TRTP_PS);
  localparam int REFRESH_CYCLE_CYC = up_cyc(REFRESH_CYCLE_TIME_PS);
  localparam int TXSNR_CYC = up_cyc(REFRESH_CYCLE_TIME_PS + TXSNR_EXTRA_PS);
  localparam int TMOD_MAX_CYC = dn_cyc(TMOD_MAX_PS);
  localparam int TOIT_MAX_CYC = dn_cyc(TOIT_MAX_PS);
  localparam int AONPD_MIN_CYC = up_cyc(AONPD_MIN_PS);
  localparam int AONPD_MAX_CYC = dn_cyc(AONPD_MAX_PS);
  localparam int AOFPD_MAX_CYC = dn_cyc(AOFPD_MAX_PS);
  localparam int TDELAY_CYC = up_cyc(TIS_PS + CLK_PERIOD_PS + TIH_PS);

  // ==========================================================
  // Commands, power states, mode field
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0, CMD_ACT = 3'h1, CMD_RD = 3'h2, CMD_WR = 3'h3,
    CMD_WRA = 3'h4, CMD_PRE = 3'h5, CMD_MRS = 3'h6, CMD_REF = 3'h7
  } dct_cmd_t;

  typedef enum logic [2:0] {
    PS_ACTIVE = 3'h1, PS_PDOWN = 3'h2, PS_SREF = 3'h4
  } dct_pstate_t;

  localparam int PS_PDOWN_BIT = 1;
  localparam int PS_SREF_BIT = 2;
  localparam int MODE_TERM_BIT = 0;
  localparam int MODE_DRIVE_BIT = 1;
  localparam logic [3:0] MODE_RESET = 4'h0;

  // Controller timer slots
  localparam int T_RRD = 0;
  localparam int T_CCD = 1;
  localparam int T_WTR = 2;
  localparam int T_RTP = 3;
  localparam int T_MRD = 4;
  localparam int T_CKE = 5;
  localparam int T_XNR = 6;
  localparam int T_XRD = 7;
  localparam int T_ANPD = 8;
  localparam int T_AXPD = 9;
  localparam int T_DLY = 10;
  localparam int T_FAW0 = 11;
  localparam int T_DAL0 = 15;
  localparam int NTMR = 19;

endpackage

// [include/dct_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Command link between controller and memory
interface dct_link_if;
  import dct_pkg::*;
  logic cke;          // Clock enable
  logic on_die_termination;          // Termination control pin
  dct_cmd_t cmd;      // Command, one per cycle
  logic [1:0] bank;   // Bank address
  logic [3:0] mode;   // Mode value for mode register set
  logic term_on;      // Termination actually applied
  logic drive_on;     // Driver calibration drive output
  modport ctrl (output cke, on_die_termination, cmd, bank, mode,
                input term_on, drive_on);
  modport dram (input cke, on_die_termination, cmd, bank, mode,
                output term_on, drive_on);
endinterface
`default_nettype wire

// [hw/dct_timer_bank.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bank of loadable down counters
module dct_timer_bank #(
  parameter int N = 1,
  parameter int W = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [N-1:0] i_load,
  input wire logic [N-1:0][W-1:0] i_val,
  output logic [N-1:0] o_zero
);
  logic [N-1:0][W-1:0] cnt_r;   // Remaining cycles
  logic [N-1:0][W-1:0] cnt_nxt;

  // Load wins over counting so a new wait is never cut short
  always_comb begin
    for (int k = 0; k < N; k++) begin
      if (i_load[k]) begin
        cnt_nxt[k] = i_val[k];
      end else if (cnt_r[k] != '0) begin
        cnt_nxt[k] = cnt_r[k] - 1'b1;
      end else begin
        cnt_nxt[k] = cnt_r[k];
      end
      o_zero[k] = (cnt_r[k] == '0);
    end
  end

  // Registers only
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule // dct_timer_bank
`default_nettype wire

// [hw/dct_dram_end.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Memory end: termination, drive mode and auto-precharge busy
module dct_dram_end
  import dct_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_write_recovery,
  input wire logic [3:0] i_precharge_period_clocks,
  output logic o_term_on,
  output logic o_drive_on,
  output logic [3:0] o_bank_busy,
  output logic o_power_down,
  output logic o_self_refresh,
  dct_link_if.dram lnk
);

  // ==========================================================
  // State
  logic [3:0] mode_r, mode_nxt;     // Applied mode value
  logic odt_d_r, odt_d_nxt;         // Pin delayed one cycle, active mode
  logic term_r, term_nxt;           // Termination applied
  logic drive_r, drive_nxt;         // Drive mode output
  logic [3:0] busy_r;               // Bank in internal precharge
  logic cke_d_r;                    // Clock enable last cycle
  dct_pstate_t pst_r, pst_nxt;      // Power state

  logic [3:0] ld;
  logic [3:0][TW-1:0] ldv;
  logic [3:0] z;

  dct_timer_bank #(.N(4), .W(TW)) u_dal (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_load(ld),
    .i_val(ldv),
    .o_zero(z)
  );

  // ==========================================================
  // Next values
  always_comb begin
    ld = '0;
    ldv = '0;
    mode_nxt = mode_r;
    pst_nxt = pst_r;
    odt_d_nxt = lnk.on_die_termination;
    // Write with auto-precharge holds the bank for WR plus precharge
    if (lnk.cmd == CMD_WRA && lnk.cke) begin
      ld[lnk.bank] = 1'b1;
      ldv[lnk.bank] = ld_cyc(int'(i_write_recovery) +
                             int'(i_precharge_period_clocks));
    end
    // New mode is live next cycle, output one later: 8 ns total
    if (lnk.cmd == CMD_MRS && lnk.cke) begin
      mode_nxt = lnk.mode;
    end
    if (cke_d_r && !lnk.cke) begin
      pst_nxt = (lnk.cmd == CMD_REF) ? PS_SREF : PS_PDOWN;
    end else if (!cke_d_r && lnk.cke) begin
      pst_nxt = PS_ACTIVE;
    end
    // In power down the pin acts in one clock, 4 ns, inside the
    // window; in active mode it takes the fixed two-clock delay
    if (pst_r == PS_ACTIVE) begin
      term_nxt = mode_r[MODE_TERM_BIT] && odt_d_r;
    end else begin
      term_nxt = mode_r[MODE_TERM_BIT] && lnk.on_die_termination;
    end
    drive_nxt = mode_r[MODE_DRIVE_BIT];
  end

  // ==========================================================
  // Registers
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_r <= MODE_RESET;
      odt_d_r <= 1'b0;
      term_r <= 1'b0;
      drive_r <= 1'b0;
      busy_r <= 4'h0;
      cke_d_r <= 1'b1;
      pst_r <= PS_ACTIVE;
    end else begin
      mode_r <= mode_nxt;
      odt_d_r <= odt_d_nxt;
      term_r <= term_nxt;
      drive_r <= drive_nxt;
      busy_r <= ~z | ld;
      cke_d_r <= lnk.cke;
      pst_r <= pst_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign lnk.term_on = term_r;
  assign lnk.drive_on = drive_r;
  assign o_term_on = term_r;
  assign o_drive_on = drive_r;
  assign o_bank_busy = busy_r;
  assign o_power_down = pst_r[PS_PDOWN_BIT];
  assign o_self_refresh = pst_r[PS_SREF_BIT];

endmodule // dct_dram_end
`default_nettype wire

// [tb/dct_link_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Link checker: spacing and termination timing on the wires
module dct_link_sva
  import dct_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic cke,
  input wire logic on_die_termination,
  input wire dct_cmd_t cmd,
  input wire logic [1:0] bank,
  input wire logic [3:0] mode,
  input wire logic term_on,
  input wire logic drive_on
);
  logic [7:0] act_r; // Activates seen in the last eight cycles
  logic col; // Column command on the link this cycle
  assign col = cmd inside {CMD_RD, CMD_WR, CMD_WRA};
  // Shift history so any nine-cycle window can be counted
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      act_r <= 8'h00;
    end else begin
      act_r <= {act_r[6:0], cmd == CMD_ACT};
    end
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ==========================================================
  // Assertions
  act_space_a: assert property (cmd == CMD_ACT |=> cmd != CMD_ACT)
    else $error("activates too close");
  act_window_a: assert property (
    $countones({act_r, cmd == CMD_ACT}) <= 4)
    else $error("five activates in window");
  col_space_a: assert property (col |=> !col)
    else $error("column commands too close");
  wr_to_rd_a: assert property (cmd == CMD_WR |=> (cmd != CMD_RD) [*7])
    else $error("read too soon after write");
  cke_pulse_a: assert property ($fell(cke) |-> !cke [*3])
    else $error("clock enable low too short");
  cke_high_a: assert property ($rose(cke) |-> cke [*3])
    else $error("clock enable high too short");
  pd_exit_a: assert property ($rose(cke) |-> cmd == CMD_NOP [*2])
    else $error("command too soon after exit");
  mrs_space_a: assert property (cmd == CMD_MRS |=> cmd == CMD_NOP)
    else $error("command too soon after mode set");
  drive_mode_a: assert property (cmd == CMD_MRS && cke |->
    ##2 drive_on == $past(mode[MODE_DRIVE_BIT], 2))
    else $error("drive mode late");
  pd_term_on_a: assert property (!cke && !$past(cke) && $rose(on_die_termination) &&
    mode[MODE_TERM_BIT] |=> term_on)
    else $error("termination on late in power down");
  pd_term_off_a: assert property (!cke && !$past(cke) && $fell(on_die_termination)
    |=> !term_on)
    else $error("termination off late in power down");
  // Main scenarios reached
  wra_c: cover property (cmd == CMD_WRA);
  sref_c: cover property ($fell(cke) && cmd == CMD_REF);
  pd_term_c: cover property (!cke && $rose(term_on));
endmodule // dct_link_sva
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Controller end facing memory end across the link
module testbench
  import dct_pkg::*;
();
  typedef struct {dct_cmd_t cmd; logic [1:0] bank; int gap;} dct_row_t;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0; // Held low for the first 16 cycles
  logic req_valid = 1'b0;
  dct_cmd_t req_cmd = CMD_NOP;
  logic [1:0] req_bank = 2'h0;
  logic cke_req = 1'b1, sref_req = 1'b0, odt_req = 1'b0;
  logic page_2kb = 1'b0, rate_1066 = 1'b1, fast_pd = 1'b1;
  logic [2:0] add_lat = 3'h0; // Zero keeps write-to-read at 8
  logic [3:0] wr_rec = 4'h4, pre_clk = 4'h3; // Auto-precharge busy 7
  logic taken, c_pd, c_sr, stop_ok, term_seen, term_on, drive_on, d_pd, d_sr;
  logic [3:0] busy;
  int mismatches = 0, checked = 0, cyc = 0, last = 0, n, t, g;
  dct_row_t rows[14];
  dct_link_if lnk();
  dct_ctrl_end i_dct_ctrl_end (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_req_valid(req_valid), .i_req_cmd(req_cmd), .i_req_bank(req_bank),
    .i_req_mode(4'h3), .i_cke_req(cke_req), .i_sref_req(sref_req),
    .i_odt_req(odt_req), .i_page_2kb(page_2kb), .i_rate_1066(rate_1066),
    .i_fast_pd_exit(fast_pd), .i_additive_latency(add_lat),
    .i_write_recovery(wr_rec), .i_precharge_period_clocks(pre_clk),
    .o_req_taken(taken), .o_power_down(c_pd), .o_self_refresh(c_sr),
    .o_clk_stop_ok(stop_ok), .o_term_seen(term_seen), .lnk(lnk));
  dct_dram_end i_dct_dram_end (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_write_recovery(wr_rec), .i_precharge_period_clocks(pre_clk),
    .o_term_on(term_on), .o_drive_on(drive_on), .o_bank_busy(busy),
    .o_power_down(d_pd), .o_self_refresh(d_sr), .lnk(lnk));
  dct_link_sva i_dct_link_sva (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .cke(lnk.cke), .on_die_termination(lnk.on_die_termination), .cmd(lnk.cmd), .bank(lnk.bank),
    .mode(lnk.mode), .term_on(lnk.term_on), .drive_on(lnk.drive_on));
  // 250 MHz clock and a free cycle count for gap measurement
  always #2 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) cyc <= cyc + 1;
  // ==========================================================
  // Shared tasks
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Settle past the edge so outputs are read after they land
  task automatic step();
    @(posedge i_sys_clk);
    #1;
    if (++n > 300) begin
      mismatches++;
      $display("mismatch at %0t: wait ran out", $time);
      summarize();
    end
  endtask
  // Valid stays up between requests; taken cycle never takes again
  task automatic issue(input dct_cmd_t c, input logic [1:0] b);
    @(posedge i_sys_clk);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_bank <= b;
    n = 0;
    do step(); while (taken !== 1'b1);
    g = cyc - last;
    last = cyc;
  endtask
  task automatic wait_cke(input logic v);
    n = 0;
    while (lnk.cke !== v) step();
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    rows = '{'{CMD_MRS, 2'h0, 0}, '{CMD_ACT, 2'h0, 2}, '{CMD_ACT, 2'h1, 2},
      '{CMD_ACT, 2'h2, 2}, '{CMD_ACT, 2'h3, 2}, '{CMD_ACT, 2'h0, 3},
      '{CMD_WR, 2'h0, 2}, '{CMD_RD, 2'h0, 8}, '{CMD_RD, 2'h0, 2},
      '{CMD_PRE, 2'h0, 2}, '{CMD_WRA, 2'h1, 2}, '{CMD_ACT, 2'h1, 7},
      '{CMD_REF, 2'h0, 2}, '{CMD_ACT, 2'h2, 27}};
    repeat (16) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      issue(rows[i].cmd, rows[i].bank);
      check(lnk.cmd, rows[i].cmd);
      if (rows[i].gap > 0) begin
        check(g, rows[i].gap);
      end
      // Bank sits in internal precharge after the auto-precharge write
      if (rows[i].cmd == CMD_WRA) begin
        step();
        check(busy, 4'h2);
      end
    end
    check(busy, 4'h0);
    $display("test command spacing done");
    @(posedge i_sys_clk);
    req_valid <= 1'b0;
    odt_req <= 1'b1;
    repeat (4) step();
    check({drive_on, term_on, term_seen}, 3'h7);
    $display("test active termination done");
    @(posedge i_sys_clk) cke_req <= 1'b0;
    wait_cke(1'b0);
    check(stop_ok, 1'b0);
    repeat (2) step();
    check({stop_ok, c_pd, d_pd, c_sr}, 4'he);
    @(posedge i_sys_clk) odt_req <= 1'b0;
    step();
    check(term_on, 1'b1);
    step();
    check(term_on, 1'b0);
    @(posedge i_sys_clk) odt_req <= 1'b1;
    repeat (2) step();
    check(term_on, 1'b1);
    @(posedge i_sys_clk) cke_req <= 1'b1;
    wait_cke(1'b1);
    last = cyc;
    issue(CMD_ACT, 2'h3);
    check(g, 3);
    @(posedge i_sys_clk);
    req_valid <= 1'b0;
    odt_req <= 1'b0;
    repeat (3) step();
    check(lnk.on_die_termination, 1'b1);
    repeat (10) step();
    check(lnk.on_die_termination, 1'b0);
    $display("test power down done");
    @(posedge i_sys_clk);
    cke_req <= 1'b0;
    sref_req <= 1'b1;
    wait_cke(1'b0);
    check({lnk.cmd, c_sr}, {CMD_REF, 1'b1});
    t = cyc;
    @(posedge i_sys_clk);
    cke_req <= 1'b1;
    sref_req <= 1'b0;
    wait_cke(1'b1);
    check(cyc - t, 3);
    check(d_sr, 1'b1);
    last = cyc;
    issue(CMD_RD, 2'h0);
    check(g, 200);
    $display("test self refresh done");
    // Slow active power-down exit: read waits 10 minus zero latency
    @(posedge i_sys_clk);
    req_valid <= 1'b0;
    fast_pd <= 1'b0;
    cke_req <= 1'b0;
    wait_cke(1'b0);
    @(posedge i_sys_clk) cke_req <= 1'b1;
    wait_cke(1'b1);
    last = cyc;
    issue(CMD_RD, 2'h0);
    check(g, 10);
    $display("test slow exit done");
    @(posedge i_sys_clk);
    req_valid <= 1'b0;
    i_rst_n <= 1'b0;
    n = 0;
    repeat (2) step();
    check({lnk.cmd, lnk.cke, lnk.on_die_termination, lnk.mode, drive_on, busy, stop_ok},
      {CMD_NOP, 1'b1, 1'b0, 4'h0, 1'b0, 4'h0, 1'b0});
    @(posedge i_sys_clk) i_rst_n <= 1'b1;
    // First request right after release must still go out
    issue(CMD_ACT, 2'h0);
    check(lnk.cmd, CMD_ACT);
    $display("test mid-run reset done");
    summarize();
  end
endmodule // testbench
`default_nettype wire
